// ---- hdl/evt_timer_cfg.svh ----
// Constants for the event counter/timer: register offsets, fields, resets.
// Assumes inclusion by bare name from design files under hdl/.
`ifndef EVT_TIMER_CFG_SVH
`define EVT_TIMER_CFG_SVH

// Register byte offsets (one aligned word each)
`define OFS_CTRL 12'h000
`define OFS_MODE 12'h004
`define OFS_RELOAD 12'h008
`define OFS_COUNTER 12'h00c
`define OFS_COMPARE 12'h010
`define OFS_STATUS 12'h014
`define OFS_OUTCFG 12'h018
`define ADDR_BITS 12

// Control register fields
`define CTRL_RUN 0
`define CTRL_DIR 1
`define CTRL_CLEAR 2

// Mode register fields
`define MODE_AUTO_RELOAD 0
`define MODE_DIR_PIN 1
`define MODE_EXT_SRC 2
`define MODE_EDGE_LO 3
`define MODE_EDGE_HI 4
`define MODE_PIN_SEL 5
`define MODE_FILTER_EN 6
`define MODE_GATE_EN 7
`define MODE_WRITE_BOTH 8
`define MODE_PERIODIC 9
`define MODE_CLR_LO 10
`define MODE_CLR_HI 11
`define MODE_DIV_LO 12
`define MODE_DIV_HI 19

// Output configuration fields
`define OUT_INIT 0
`define OUT_ACT_LO 1
`define OUT_ACT_HI 2
`define OUT_PULSE 3
`define OUT_GPIO 4
`define OUT_LOAD 5

// Status fields
`define STAT_WRAP 0
`define STAT_MATCH 1
`define STAT_RUN 2
`define STAT_CMP 3
`define STAT_RAO 4

// Reset values
`define RST_MODE 32'h0000_0000
`define RST_RELOAD 32'h0000_0000
`define RST_COMPARE 32'h0000_ffff
`define RST_OUTCFG 32'h0000_0000

`endif

// ---- hdl/evt_timer_pkg.sv ----
// Types shared by the event counter/timer design files.
// Assumes evt_timer_cfg.svh holds all numeric constants.
package evt_timer_pkg;

    // Edge that advances the counter on an external source
    typedef enum logic [1:0] {
        EDGE_RISE = 2'h0,
        EDGE_FALL = 2'h1,
        EDGE_BOTH = 2'h2
    } edge_sel_e;

    // Compare-match output action
    typedef enum logic [1:0] {
        ACT_RETAIN = 2'h0,
        ACT_LOW = 2'h1,
        ACT_HIGH = 2'h2,
        ACT_TOGGLE = 2'h3
    } match_act_e;

    // Counter clear source
    typedef enum logic [1:0] {
        CLR_NONE = 2'h0,
        CLR_COMPARE = 2'h1,
        CLR_GATE_PIN = 2'h2,
        CLR_SOFT = 2'h3
    } clr_src_e;

    // Bus phase state, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DATA = 2'b10
    } bus_state_e;

    // External event pins into the front end
    typedef struct packed {
        logic event_a;
        logic event_b;
        logic gate_input_pin;
        logic timer_a_io_pin;
    } ext_pins_s;

    // Front-end settings
    typedef struct packed {
        logic pin_sel;
        logic filter_en;
        logic [7:0] sample_div;
        edge_sel_e edge_sel;
        logic gate_en;
    } front_cfg_s;

endpackage

// ---- hdl/event_front.sv ----
// External event front end: pin choice, sampling filter, edge detect, gate.
// Assumes pins synchronous to hclk; emits a one-cycle count pulse.
`timescale 1ns/100ps
`default_nettype none
`include "evt_timer_cfg.svh"

module event_front
    import evt_timer_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Pins and settings
    input wire ext_pins_s pins,
    input wire front_cfg_s cfg,
    // Count strobe
    output logic count_pulse
);

    logic raw;
    logic [7:0] div_reg;
    logic sample_tick;
    logic level_reg;
    logic prev_reg;
    logic rise;
    logic fall;

    // Input pin choice
    assign raw = cfg.pin_sel ? pins.event_b : pins.event_a;

    // Sample tick every sample_div+1 cycles; filter hides glitches between ticks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= 8'h00;
        end else if (div_reg >= cfg.sample_div) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end
    assign sample_tick = !cfg.filter_en || (div_reg >= cfg.sample_div);

    // Sampled level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_reg <= 1'b0;
        end else if (sample_tick) begin
            level_reg <= raw;
        end
    end

    // Previous level for edge detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= level_reg;
        end
    end

    assign rise = level_reg && !prev_reg;
    assign fall = !level_reg && prev_reg;

    // Edge choice and gate
    always_comb begin
        unique case (cfg.edge_sel)
            EDGE_RISE: count_pulse = rise;
            EDGE_FALL: count_pulse = fall;
            EDGE_BOTH: count_pulse = rise || fall;
            default: count_pulse = 1'b0;
        endcase
        if (cfg.gate_en && !pins.gate_input_pin) begin
            count_pulse = 1'b0;
        end
    end

endmodule
`default_nettype wire

// ---- hdl/event_counter_timer.sv ----
// Event counter/timer channel with AHB-Lite register slave.
// Assumes one hclk domain; event pins synchronous to hclk.
// Operation
// - Retain option keeps compare output level unchanged on matches.
// - Compare output starts at programmable level; match drives 0, 1 or toggles.
// - Initial level and match actions apply only in periodic operation.
// - Auto-reload on: wrap loads reload value and counting continues.
// - Auto-reload off: wrap does not load the reload value.
// - Software direction flag selects up or down counting.
// - Pin direction: timer_a_io_pin low counts down, high counts up.
// - External events count on rising, falling or both edges.
// - Reload-only write mode updates reload register, counter untouched.
// - Write-both mode updates reload register and counter together.
// - Gate on: external events count only while gate input pin high; internal clock counting ignores it; off ignores it.
// - Filter samples the external event at a configurable rate.
// - Configuration selects which input pin supplies external events.
// - Selectable source clears the counter.
// - Timer output pin acts as general I/O or pulse output.
// - Periodic operation clears counter on compare match.
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "evt_timer_cfg.svh"

module event_counter_timer
    import evt_timer_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Event pins
    input wire ext_pins_s pins,
    // Outputs
    output logic compare_output_pin,
    output logic timer_ra_output_pin
);

    bus_state_e bus_reg;
    logic [`ADDR_BITS-1:0] addr_reg;
    logic write_reg;
    logic run_reg;
    logic dir_flag_reg;
    logic soft_clr;
    logic [31:0] mode_reg;
    logic [WIDTH-1:0] reload_reg;
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] compare_reg;
    logic [5:0] outcfg_reg;
    logic wrap_flag_reg;
    logic match_flag_reg;
    logic pulse_reg;
    logic count_pulse;
    logic tick;
    logic up;
    logic match;
    logic wrap;
    logic clr;
    logic periodic;
    logic wr_reload;
    logic wr_counter;
    logic wr_ctrl;
    logic wr_mode;
    logic wr_cmp;
    logic wr_out;
    logic wr_stat;
    logic [WIDTH-1:0] wdata;
    match_act_e act;
    clr_src_e clr_src;
    front_cfg_s fcfg;

    // Register write strobe for one offset in the data phase
    function automatic logic wr_hit(input logic [`ADDR_BITS-1:0] ofs);
        return (bus_reg == BUS_DATA) && write_reg && (addr_reg == ofs);
    endfunction

    // Bus phase tracking; slave never inserts wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_reg <= BUS_IDLE;
            addr_reg <= '0;
            write_reg <= 1'b0;
        end else if (hready && hsel && htrans[1]) begin
            bus_reg <= BUS_DATA;
            addr_reg <= haddr[`ADDR_BITS-1:0];
            write_reg <= hwrite;
        end else if (hready) begin
            bus_reg <= BUS_IDLE;
        end
    end

    assign wdata = hwdata[WIDTH-1:0];
    assign wr_ctrl = wr_hit(`OFS_CTRL);
    assign wr_mode = wr_hit(`OFS_MODE);
    assign wr_reload = wr_hit(`OFS_RELOAD);
    assign wr_counter = wr_hit(`OFS_COUNTER);
    assign wr_cmp = wr_hit(`OFS_COMPARE);
    assign wr_out = wr_hit(`OFS_OUTCFG);
    assign wr_stat = wr_hit(`OFS_STATUS);

    // Control bits; clear bit is a self-clearing strobe
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_reg <= 1'b0;
            dir_flag_reg <= 1'b0;
        end else if (wr_ctrl) begin
            run_reg <= hwdata[`CTRL_RUN];
            dir_flag_reg <= hwdata[`CTRL_DIR];
        end
    end
    assign soft_clr = wr_ctrl && hwdata[`CTRL_CLEAR];

    // Configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= `RST_MODE;
            compare_reg <= WIDTH'(`RST_COMPARE);
            outcfg_reg <= 6'(`RST_OUTCFG);
        end else begin
            if (wr_mode) begin
                mode_reg <= hwdata;
            end
            if (wr_cmp) begin
                compare_reg <= wdata;
            end
            if (wr_out) begin
                outcfg_reg <= hwdata[5:0];
            end
        end
    end

    // Reload register written in both write modes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload_reg <= WIDTH'(`RST_RELOAD);
        end else if (wr_reload || wr_counter) begin
            reload_reg <= wdata;
        end
    end

    // Front-end settings
    assign fcfg.pin_sel = mode_reg[`MODE_PIN_SEL];
    assign fcfg.filter_en = mode_reg[`MODE_FILTER_EN];
    assign fcfg.sample_div = mode_reg[`MODE_DIV_HI:`MODE_DIV_LO];
    assign fcfg.edge_sel = edge_sel_e'(mode_reg[`MODE_EDGE_HI:`MODE_EDGE_LO]);
    assign fcfg.gate_en = mode_reg[`MODE_GATE_EN];

    event_front u_front (
        .hclk(hclk),
        .hresetn(hresetn),
        .pins(pins),
        .cfg(fcfg),
        .count_pulse(count_pulse)
    );

    // Count tick: external pulse or every clock; none while stopped
    assign tick = run_reg && (mode_reg[`MODE_EXT_SRC] ? count_pulse : 1'b1);

    // Direction source
    assign up = mode_reg[`MODE_DIR_PIN] ? pins.timer_a_io_pin : dir_flag_reg;

    assign periodic = mode_reg[`MODE_PERIODIC];
    assign clr_src = clr_src_e'(mode_reg[`MODE_CLR_HI:`MODE_CLR_LO]);
    assign match = tick && (count_reg == compare_reg);
    // A clear from any source beats wrap; a bare match must not block reload
    assign wrap = tick && !clr && (up ? &count_reg : ~|count_reg);

    // Clear source choice periodic forces compare clear
    always_comb begin
        unique case (clr_src)
            CLR_NONE: clr = periodic && match;
            CLR_COMPARE: clr = match;
            CLR_GATE_PIN: clr = pins.gate_input_pin || (periodic && match);
            CLR_SOFT: clr = soft_clr || (periodic && match);
        endcase
    end

    // Counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= '0;
        end else if (wr_counter && mode_reg[`MODE_WRITE_BOTH]) begin
            count_reg <= wdata;
        end else if (clr) begin
            count_reg <= '0;
        end else if (wrap && mode_reg[`MODE_AUTO_RELOAD]) begin
            count_reg <= reload_reg;
        end else if (tick) begin
            // Free wrap without reload reload-only write skips here
            count_reg <= up ? count_reg + 1'b1 : count_reg - 1'b1;
        end
    end

    // Sticky flags; a new event wins over a software clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wrap_flag_reg <= 1'b0;
            match_flag_reg <= 1'b0;
        end else begin
            wrap_flag_reg <= wrap || (wrap_flag_reg && !(wr_stat && hwdata[`STAT_WRAP]));
            match_flag_reg <= match || (match_flag_reg && !(wr_stat && hwdata[`STAT_MATCH]));
        end
    end

    // Compare output pin; init and actions only in periodic mode
    assign act = match_act_e'(outcfg_reg[`OUT_ACT_HI:`OUT_ACT_LO]);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_output_pin <= 1'b0;
        end else if (wr_out && hwdata[`OUT_LOAD] && periodic) begin
            compare_output_pin <= hwdata[`OUT_INIT];
        end else if (match && periodic) begin
            unique case (act)
                ACT_RETAIN: compare_output_pin <= compare_output_pin;
                ACT_LOW: compare_output_pin <= 1'b0;
                ACT_HIGH: compare_output_pin <= 1'b1;
                ACT_TOGGLE: compare_output_pin <= !compare_output_pin;
            endcase
        end
    end

    // Pulse output flips once in any cycle with a wrap, a match or both
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_reg <= 1'b0;
        end else if (wrap || match) begin
            pulse_reg <= !pulse_reg;
        end
    end

    // Timer output pin: port level or pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_ra_output_pin <= 1'b0;
        end else if (outcfg_reg[`OUT_PULSE]) begin
            timer_ra_output_pin <= pulse_reg;
        end else begin
            timer_ra_output_pin <= outcfg_reg[`OUT_GPIO];
        end
    end

    // Read data, registered at the address phase for zero-wait answers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr[`ADDR_BITS-1:0])
                `OFS_CTRL: hrdata <= {30'h0, dir_flag_reg, run_reg};
                `OFS_MODE: hrdata <= mode_reg;
                `OFS_RELOAD: hrdata <= 32'(reload_reg);
                `OFS_COUNTER: hrdata <= 32'(count_reg);
                `OFS_COMPARE: hrdata <= 32'(compare_reg);
                `OFS_STATUS: hrdata <= {27'h0, timer_ra_output_pin, compare_output_pin,
                                         run_reg, match_flag_reg, wrap_flag_reg};
                `OFS_OUTCFG: hrdata <= {26'h0, outcfg_reg};
                default: hrdata <= '0;
            endcase
        end
    end

    // Always ready, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ---- test/evt_source.sv ----
// Far-side model: external event source plus gate and direction levels.
// Assumes the bench calls its tasks just after a rising hclk edge.
`timescale 1ns/100ps
`default_nettype none
module evt_source
    import evt_timer_pkg::*;
(
    // Clock
    input wire logic hclk,
    // Pins toward the channel
    output var ext_pins_s pins
);
    // All pins idle low until a scenario moves them
    initial pins = '0;
    // Whole pulses, eight cycles per level so a slow filter still sees them
    task automatic pulse(input int n, input logic on_b);
        repeat (n) begin
            @(posedge hclk);
            pins.event_a <= !on_b;
            pins.event_b <= on_b;
            repeat (8) @(posedge hclk);
            pins.event_a <= 1'b0;
            pins.event_b <= 1'b0;
            repeat (8) @(posedge hclk);
        end
    endtask
    // Gate and direction levels, changed only between pulses
    task automatic lv(input logic g, input logic d);
        pins.gate_input_pin <= g;
        pins.timer_a_io_pin <= d;
    endtask
endmodule
`default_nettype wire

// ---- test/event_counter_timer_props.sv ----
// Port-level checker for the event counter/timer channel.
// Assumes one hclk domain and zero-wait AHB-Lite transfers.
`timescale 1ns/100ps
`default_nettype none
`include "evt_timer_cfg.svh"
module event_counter_timer_props (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Outputs
    input wire logic compare_output_pin,
    input wire logic timer_ra_output_pin
);
    logic a_wr;
    logic [11:0] a_ad;
    logic [31:0] mode_sh, out_sh, rel_sh;
    logic [1:0] oq;
    wire logic take = hsel && hready && htrans[1];
    wire logic wr_out = a_wr && a_ad == `OFS_OUTCFG;
    wire logic quiet = !wr_out && oq == 2'h0;
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Address phase kept for its data phase; oq masks pin settling after writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_wr <= 1'b0;
            a_ad <= 12'h0;
            oq <= 2'h0;
        end else begin
            a_wr <= take && hwrite;
            a_ad <= haddr[11:0];
            oq <= {oq[0], wr_out};
        end
    end
    // Shadows of written settings; counter writes always reach reload
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_sh <= `RST_MODE;
            out_sh <= `RST_OUTCFG;
            rel_sh <= `RST_RELOAD;
        end else if (a_wr) begin
            if (a_ad == `OFS_MODE) mode_sh <= hwdata;
            if (a_ad == `OFS_OUTCFG) out_sh <= hwdata;
            if (a_ad == `OFS_RELOAD || a_ad == `OFS_COUNTER) rel_sh <= hwdata;
        end
    end
    chk_bus_ready: assert property (hreadyout)
        else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    chk_unmapped_zero: assert property (take && !hwrite && haddr[11:0] >= 12'h01c
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
    chk_reload_readback:
    assert property (take && !hwrite && !a_wr && haddr[11:0] == `OFS_RELOAD
        |=> hrdata[15:0] == rel_sh[15:0]) else $error("reload readback wrong");
    chk_retain_level:
    assert property (quiet && out_sh[2:1] == 2'h0 |-> $stable(compare_output_pin))
        else $error("compare pin moved under retain");
    chk_nonperiodic_hold:
    assert property (!mode_sh[9] && !$past(mode_sh[9]) && !$past(mode_sh[9], 2)
        |-> $stable(compare_output_pin)) else $error("compare pin moved outside periodic");
    chk_port_level:
    assert property (quiet && !out_sh[3] |-> timer_ra_output_pin == out_sh[4])
        else $error("port level wrong");
    chk_high_no_fall:
    assert property (quiet && mode_sh[9] && out_sh[2:1] == 2'h2 |-> !$fell(compare_output_pin))
        else $error("compare pin fell under drive-high");
    cover property (take && hwrite && haddr[11:0] == `OFS_COUNTER);
    cover property (mode_sh[9] && $rose(compare_output_pin));
    cover property (mode_sh[9] && $fell(compare_output_pin));
endmodule
bind event_counter_timer event_counter_timer_props chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .compare_output_pin(compare_output_pin),
    .timer_ra_output_pin(timer_ra_output_pin));
`default_nettype wire

// ---- test/event_counter_timer_tb.sv ----
// Self-checking bench for the event counter/timer channel.
// Assumes evt_source drives the pins and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
`include "evt_timer_cfg.svh"
module event_counter_timer_tb
    import evt_timer_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cmp_pin, ra_pin;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [31:0] act_exp [4];
    ext_pins_s pins;
    int mismatches, compares, e, a;
    event_counter_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pins(pins), .compare_output_pin(cmp_pin), .timer_ra_output_pin(ra_pin));
    evt_source src (.hclk(hclk), .pins(pins));
    // 50 MHz clock
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    task print_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task cmp(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    // Bounded wait for hready; a hang ends the run as a failure
    task wt;
        int i;
        i = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            i++;
            if (i > 64) begin
                mismatches++;
                print_verdict;
            end
            @(posedge hclk);
        end
    endtask
    // One single transfer; read data taken at the data-phase edge
    task xfer(input logic w, input logic [11:0] ad, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, ad};
        wt;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt;
        r = hrdata;
    endtask
    task wr(input logic [11:0] ad, input logic [31:0] d);
        xfer(1'b1, ad, d);
    endtask
    task ck(input logic [11:0] ad, input logic [31:0] x);
        xfer(1'b0, ad, 32'h0);
        cmp(r, x);
    endtask
    task cn(input logic [31:0] x);
        ck(`OFS_COUNTER, x);
    endtask
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        mismatches = 0;
        compares = 0;
        act_exp = '{32'h1, 32'h0, 32'h1, 32'h0};
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values; unmapped offset ignores writes
        ck(`OFS_COMPARE, 32'hffff);
        ck(`OFS_OUTCFG, 32'h0);
        wr(12'h01c, 32'h5a5a_5a5a);
        ck(12'h01c, 32'h0);
        // Reload-only write leaves the count alone
        wr(`OFS_COUNTER, 32'h5);
        cn(32'h0);
        ck(`OFS_RELOAD, 32'h5);
        wr(`OFS_MODE, 32'h104);
        wr(`OFS_COUNTER, 32'h20);
        cn(32'h20);
        ck(`OFS_RELOAD, 32'h20);
        // Flag direction; gate off counts with the gate pin low
        wr(`OFS_CTRL, 32'h3);
        src.pulse(3, 1'b0);
        cn(32'h23);
        wr(`OFS_CTRL, 32'h1);
        src.pulse(2, 1'b0);
        cn(32'h21);
        // Stopped channel holds, then resumes from the held count
        wr(`OFS_CTRL, 32'h0);
        src.pulse(2, 1'b0);
        cn(32'h21);
        wr(`OFS_CTRL, 32'h3);
        src.pulse(1, 1'b0);
        cn(32'h22);
        for (e = 0; e < 3; e++) begin
            wr(`OFS_MODE, 32'h104 | (e << 3));
            wr(`OFS_COUNTER, 32'h0);
            src.pulse(2, 1'b0);
            cn((e == 2) ? 32'h4 : 32'h2);
        end
        // Second pin selected: pulses on the first are ignored
        wr(`OFS_MODE, 32'h124);
        wr(`OFS_COUNTER, 32'h0);
        src.pulse(2, 1'b0);
        src.pulse(3, 1'b1);
        cn(32'h3);
        wr(`OFS_MODE, 32'h3144);
        wr(`OFS_COUNTER, 32'h0);
        src.pulse(2, 1'b0);
        cn(32'h2);
        wr(`OFS_MODE, 32'h184);
        wr(`OFS_COUNTER, 32'h0);
        src.pulse(2, 1'b0);
        cn(32'h0);
        src.lv(1'b1, 1'b0);
        src.pulse(2, 1'b0);
        cn(32'h2);
        // Pin direction overrides a down flag
        wr(`OFS_MODE, 32'h106);
        wr(`OFS_CTRL, 32'h1);
        src.lv(1'b0, 1'b1);
        src.pulse(3, 1'b0);
        cn(32'h5);
        src.lv(1'b0, 1'b0);
        src.pulse(2, 1'b0);
        cn(32'h3);
        // Underflow wraps freely, then overflow with reload and onward
        wr(`OFS_MODE, 32'h104);
        wr(`OFS_COUNTER, 32'h0);
        wr(`OFS_MODE, 32'h004);
        wr(`OFS_RELOAD, 32'h10);
        src.pulse(1, 1'b0);
        cn(32'hffff);
        wr(`OFS_MODE, 32'h005);
        wr(`OFS_CTRL, 32'h3);
        src.pulse(1, 1'b0);
        cn(32'h10);
        wr(`OFS_CTRL, 32'h1);
        src.pulse(1, 1'b0);
        cn(32'hf);
        // Sticky flags: wrap and match set, write 1 clears both
        ck(`OFS_STATUS, 32'h7);
        wr(`OFS_STATUS, 32'h3);
        ck(`OFS_STATUS, 32'h4);
        wr(`OFS_MODE, 32'hc04);
        wr(`OFS_CTRL, 32'h7);
        cn(32'h0);
        // Init load is ignored outside periodic operation
        wr(`OFS_MODE, 32'h104);
        wr(`OFS_OUTCFG, 32'h21);
        repeat (2) @(posedge hclk);
        cmp({31'h0, cmp_pin}, 32'h0);
        // Every match action, compare value 3
        for (a = 0; a < 4; a++) begin
            wr(`OFS_MODE, 32'h304);
            wr(`OFS_COMPARE, 32'h3);
            wr(`OFS_COUNTER, 32'h0);
            wr(`OFS_OUTCFG, 32'h20 | (a << 1) | (a != 2));
            repeat (2) @(posedge hclk);
            cmp({31'h0, cmp_pin}, (a != 2) ? 32'h1 : 32'h0);
            // Match lands on the event taken at the compare value
            src.pulse(4, 1'b0);
            cmp({31'h0, cmp_pin}, act_exp[a]);
            src.pulse(2, 1'b0);
            cn(32'h2);
        end
        wr(`OFS_OUTCFG, 32'h10);
        repeat (2) @(posedge hclk);
        cmp({31'h0, ra_pin}, 32'h1);
        // Pulse output flips once for the single match in two events
        wr(`OFS_OUTCFG, 32'h08);
        repeat (2) @(posedge hclk);
        r = {31'h0, ra_pin};
        src.pulse(2, 1'b0);
        cmp({31'h0, ra_pin}, r ^ 32'h1);
        print_verdict;
    end
endmodule
`default_nettype wire
